// *** src/ivpc_pkg.sv ***
// ivpc_pkg: register map, field layout and carriers for the vectored
// interrupt configuration block.
// assumes one 125 MHz clock domain and a 16-bit register byte address.
package ivpc_pkg;

	localparam int ADDR_W = 16;
	localparam int SRC_N = 16;
	localparam int GROUP_N = 4;
	localparam int LANE_W = 8;
	localparam int PRI_W = 3;
	localparam int SUB_W = 2;
	localparam int NUM_W = 8;
	localparam int EXT_N = 5;
	localparam int SS_W = 4;
	localparam int VS_W = 7;
	localparam int SPACING_W = 10;
	localparam int OFFSET_W = 18;

	// base offsets; alias companions sit at +0x4, +0x8, +0xC
	localparam logic [15:0] OFS_CONTROL = 16'hF000;
	localparam logic [15:0] OFS_SHADOW = 16'hF010;
	localparam logic [15:0] OFS_STATUS = 16'hF020;
	localparam logic [15:0] OFS_PROX_RELOAD = 16'hF030;
	localparam logic [15:0] OFS_FLAGS = 16'hF040;
	localparam logic [15:0] OFS_ENABLES = 16'hF0C0;
	localparam logic [15:0] OFS_PRIO_G8 = 16'hF1C0;
	localparam logic [15:0] OFS_PRIO_G9 = 16'hF1D0;
	localparam logic [15:0] OFS_PRIO_G10 = 16'hF1E0;
	localparam logic [15:0] OFS_PRIO_G11 = 16'hF1F0;
	localparam logic [15:0] OFS_BASE_MASK = 16'hFFF0;

	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_CLEAR = 2'h1;
	localparam logic [1:0] OP_SET = 2'h2;
	localparam logic [1:0] OP_TOGGLE = 2'h3;

	localparam logic [31:0] CONTROL_MASK = 32'h007F171F;
	localparam logic [31:0] SHADOW_MASK = 32'hFFFFFFF1;
	localparam logic [31:0] STATUS_MASK = 32'h000007FF;
	localparam logic [31:0] RESET_VALUE = 32'h00000000;

	localparam int VS_LSB = 16;
	localparam int MULTI_VECTOR_SELECT_BIT = 12;
	localparam int TPC_LSB = 8;
	localparam int EP_LSB = 0;
	localparam int SS0_BIT = 0;
	localparam int SINGLE_REQ_LEVEL_LSB = 8;
	localparam int LAST_SERVICED_NUMBER_LSB = 0;
	localparam int PRI_LSB = 2;
	localparam int VS_UNIT_SHIFT = 3;
	localparam logic [SS_W-1:0] SS_SET1 = 4'h1;

	// implemented priority lanes per group, index 0 = group 8
	localparam logic [GROUP_N-1:0][31:0] PRIO_MASK_FULL =
		{32'h1F1F0000, 32'h001F1F1F, 32'h1F1F1F00, 32'h001F1F1F};
	localparam logic [GROUP_N-1:0][31:0] PRIO_MASK_SMALL =
		{32'h1F1F0000, 32'h001F1F1F, 32'h00001F00, 32'h001F1F1F};
	localparam logic [SRC_N-1:0] SRC_MASK_FULL = 16'hC7E7;
	localparam logic [SRC_N-1:0] SRC_MASK_SMALL = 16'hC727;

	// source fed by each external pin
	localparam logic [EXT_N-1:0][3:0] EXT_SRC =
		{4'h8, 4'h7, 4'h5, 4'h1, 4'h0};

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic valid;
		logic [3:0] id;
		logic [PRI_W-1:0] pri;
		logic [SUB_W-1:0] sub;
	} ivpc_pick_s;

	typedef struct packed {
		logic valid;
		logic [NUM_W-1:0] number;
		logic [PRI_W-1:0] level;
		logic shadow_set;
		logic [31:0] vector_addr;
	} ivpc_present_s;

endpackage : ivpc_pkg

// *** src/ivpc_arbiter.sv ***
// ivpc_arbiter: picks the highest priority pending, enabled source.
// assumes pending is already masked by the enables and implemented lanes.
`timescale 1ns/1ps
`default_nettype none
module ivpc_arbiter (
	input wire logic [ivpc_pkg::SRC_N-1:0] i_pending, // pending and enabled
	input wire logic [ivpc_pkg::GROUP_N-1:0][31:0] i_prio, // group regs
	output ivpc_pkg::ivpc_pick_s o_pick // winning source
);

	logic [ivpc_pkg::SRC_N-1:0][ivpc_pkg::PRI_W-1:0] src_pri;
	logic [ivpc_pkg::SRC_N-1:0][ivpc_pkg::SUB_W-1:0] src_sub;

	genvar g;
	generate
		for (g = 0; g < ivpc_pkg::SRC_N; g++) begin : g_src
			localparam int GRP = g / 4;
			localparam int LSB = (g % 4) * ivpc_pkg::LANE_W;
			assign src_pri[g] = i_prio[GRP][LSB+ivpc_pkg::PRI_LSB +:
				ivpc_pkg::PRI_W];
			assign src_sub[g] = i_prio[GRP][LSB +: ivpc_pkg::SUB_W];
		end
	endgenerate

	// level 0 never wins; equal keys keep the lower source number
	always_comb begin
		o_pick = '0;
		for (int s = 0; s < ivpc_pkg::SRC_N; s++) begin
			if (i_pending[s] && (src_pri[s] != '0) &&
				(!o_pick.valid ||
				{src_pri[s], src_sub[s]} > {o_pick.pri, o_pick.sub})) begin
				o_pick.valid = 1'b1;
				o_pick.id = 4'(s);
				o_pick.pri = src_pri[s];
				o_pick.sub = src_sub[s];
			end
		end
	end

endmodule : ivpc_arbiter
`default_nettype wire

// *** src/ivpc_ctrl.sv ***
// ivpc_ctrl: configuration registers of the vectored interrupt controller
// with an AXI4-Lite slave, flag capture and vector presentation.
// assumes peripheral requests are same-clock pulses, external pins are
// asynchronous, and the core acknowledges with a same-clock pulse.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module ivpc_ctrl #(
	parameter logic SMALL_PKG = 1'b0,
	parameter logic [31:0] VECTOR_BASE = 32'h00000000
) (
	input wire logic i_clk, // 125 MHz system clock
	input wire logic i_reset, // synchronous, active high
	input wire logic [15:0] i_s_axi_awaddr, // write address
	input wire logic i_s_axi_awvalid, // write address valid
	output logic o_s_axi_awready, // write address ready
	input wire logic [31:0] i_s_axi_wdata, // write data
	input wire logic [3:0] i_s_axi_wstrb, // byte strobes
	input wire logic i_s_axi_wvalid, // write data valid
	output logic o_s_axi_wready, // write data ready
	output logic [1:0] o_s_axi_bresp, // write response
	output logic o_s_axi_bvalid, // write response valid
	input wire logic i_s_axi_bready, // write response ready
	input wire logic [15:0] i_s_axi_araddr, // read address
	input wire logic i_s_axi_arvalid, // read address valid
	output logic o_s_axi_arready, // read address ready
	output logic [31:0] o_s_axi_rdata, // read data
	output logic [1:0] o_s_axi_rresp, // read response
	output logic o_s_axi_rvalid, // read data valid
	input wire logic i_s_axi_rready, // read data ready
	input wire logic [15:0] i_irq_req, // peripheral request pulses
	input wire logic [4:0] i_ext_irq, // asynchronous external pins
	input wire logic i_irq_ack, // core takes the presented vector
	output ivpc_pkg::ivpc_present_s o_present, // vector to the core
	output logic o_prox_start, // proximity timer start pulse
	output logic [31:0] o_prox_reload // proximity timer reload value
);

	////////////////////////////////////////////////////////////////////////
	// implemented-bit masks

	wire logic [ivpc_pkg::GROUP_N-1:0][31:0] prio_mask = SMALL_PKG ?
		ivpc_pkg::PRIO_MASK_SMALL : ivpc_pkg::PRIO_MASK_FULL;
	wire logic [ivpc_pkg::SRC_N-1:0] src_mask = SMALL_PKG ?
		ivpc_pkg::SRC_MASK_SMALL : ivpc_pkg::SRC_MASK_FULL;

	////////////////////////////////////////////////////////////////////////
	// registers

	logic [31:0] control;
	logic [31:0] shadow;
	logic [31:0] prox_reload;
	logic [ivpc_pkg::SRC_N-1:0] flags;
	logic [ivpc_pkg::SRC_N-1:0] enables;
	logic [ivpc_pkg::GROUP_N-1:0][31:0] prio;
	logic [ivpc_pkg::NUM_W-1:0] last_serviced_number;
	logic [ivpc_pkg::PRI_W-1:0] single_req_level;

	wire logic multi_vector_select = control[ivpc_pkg::MULTI_VECTOR_SELECT_BIT];
	wire logic [ivpc_pkg::VS_W-1:0] vector_spacing =
		control[ivpc_pkg::VS_LSB +: ivpc_pkg::VS_W];
	wire logic [ivpc_pkg::PRI_W-1:0] proximity_trigger_level =
		control[ivpc_pkg::TPC_LSB +: ivpc_pkg::PRI_W];
	wire logic [ivpc_pkg::EXT_N-1:0] ext_edge_pol =
		control[ivpc_pkg::EP_LSB +: ivpc_pkg::EXT_N];
	wire logic single_vector_shadow = shadow[ivpc_pkg::SS0_BIT];

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path

	logic aw_held;
	logic w_held;
	logic [15:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	wire logic aw_take = i_s_axi_awvalid && o_s_axi_awready;
	wire logic w_take = i_s_axi_wvalid && o_s_axi_wready;
	wire logic do_write = aw_held && w_held && !o_s_axi_bvalid;
	wire logic next_bvalid = do_write ||
		(o_s_axi_bvalid && !i_s_axi_bready);
	wire logic next_aw_held = do_write ? 1'b0 : (aw_held || aw_take);
	wire logic next_w_held = do_write ? 1'b0 : (w_held || w_take);

	wire logic [15:0] w_base = aw_addr & ivpc_pkg::OFS_BASE_MASK;
	wire logic [1:0] w_op = aw_addr[3:2];

	wire logic [31:0] byte_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
		{8{w_strb[1]}}, {8{w_strb[0]}}};
	wire logic [31:0] w_bits = w_data & byte_mask;

	wire logic hit_control = w_base == ivpc_pkg::OFS_CONTROL;
	wire logic hit_shadow = w_base == ivpc_pkg::OFS_SHADOW;
	wire logic hit_status = w_base == ivpc_pkg::OFS_STATUS;
	wire logic hit_reload = w_base == ivpc_pkg::OFS_PROX_RELOAD;
	wire logic hit_flags = w_base == ivpc_pkg::OFS_FLAGS;
	wire logic hit_enables = w_base == ivpc_pkg::OFS_ENABLES;
	wire logic [ivpc_pkg::GROUP_N-1:0] hit_prio = {
		w_base == ivpc_pkg::OFS_PRIO_G11,
		w_base == ivpc_pkg::OFS_PRIO_G10,
		w_base == ivpc_pkg::OFS_PRIO_G9,
		w_base == ivpc_pkg::OFS_PRIO_G8};
	// status is read-only, so a write to it still answers OKAY
	wire logic w_mapped = hit_control || hit_shadow || hit_status ||
		hit_reload || hit_flags || hit_enables || (|hit_prio);

	// one update path keeps the four alias flavours identical everywhere
	function automatic logic [31:0] alter(input logic [1:0] op,
		input logic [31:0] old, input logic [31:0] bits,
		input logic [31:0] bmask, input logic [31:0] impl);
		logic [31:0] res;
		case (op)
			ivpc_pkg::OP_CLEAR: res = old & ~bits;
			ivpc_pkg::OP_SET: res = old | bits;
			ivpc_pkg::OP_TOGGLE: res = old ^ bits;
			default: res = (old & ~bmask) | bits;
		endcase
		return res & impl;
	endfunction : alter

	wire logic [31:0] next_control = (do_write && hit_control) ?
		alter(w_op, control, w_bits, byte_mask, ivpc_pkg::CONTROL_MASK) :
		control;
	wire logic [31:0] next_shadow = (do_write && hit_shadow) ?
		alter(w_op, shadow, w_bits, byte_mask, ivpc_pkg::SHADOW_MASK) :
		shadow;
	wire logic [31:0] next_reload = (do_write && hit_reload) ?
		alter(w_op, prox_reload, w_bits, byte_mask, '1) : prox_reload;
	wire logic [31:0] flags_sw = (do_write && hit_flags) ?
		alter(w_op, {16'h0000, flags}, w_bits, byte_mask,
		{16'h0000, src_mask}) : {16'h0000, flags};
	wire logic [31:0] enables_sw = (do_write && hit_enables) ?
		alter(w_op, {16'h0000, enables}, w_bits, byte_mask,
		{16'h0000, src_mask}) : {16'h0000, enables};

	////////////////////////////////////////////////////////////////////////
	// external pins and request capture

	logic [ivpc_pkg::EXT_N-1:0] ext_meta;
	logic [ivpc_pkg::EXT_N-1:0] ext_sync;
	logic [ivpc_pkg::EXT_N-1:0] ext_prev;
	logic [ivpc_pkg::SRC_N-1:0] ext_req;

	// polarity one picks the rising edge, zero the falling edge
	wire logic [ivpc_pkg::EXT_N-1:0] ext_edge =
		(ext_sync & ~ext_prev & ext_edge_pol) |
		(~ext_sync & ext_prev & ~ext_edge_pol);

	always_comb begin
		ext_req = '0;
		for (int k = 0; k < ivpc_pkg::EXT_N; k++) begin
			ext_req[ivpc_pkg::EXT_SRC[k]] = ext_req[ivpc_pkg::EXT_SRC[k]] |
				ext_edge[k];
		end
	end

	// a request in the clearing cycle survives the clear
	wire logic [ivpc_pkg::SRC_N-1:0] next_flags =
		(flags_sw[ivpc_pkg::SRC_N-1:0] | i_irq_req | ext_req) &
		src_mask;

	////////////////////////////////////////////////////////////////////////
	// priority groups

	logic [ivpc_pkg::GROUP_N-1:0][31:0] next_prio;

	genvar g;
	generate
		for (g = 0; g < ivpc_pkg::GROUP_N; g++) begin : g_prio
			assign next_prio[g] = (do_write && hit_prio[g]) ?
				alter(w_op, prio[g], w_bits, byte_mask, prio_mask[g]) :
				prio[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// arbitration and vector formation

	ivpc_pkg::ivpc_pick_s pick;

	ivpc_arbiter u_arbiter (
		.i_pending(flags & enables),
		.i_prio(prio),
		.o_pick(pick)
	);

	wire logic [ivpc_pkg::SPACING_W-1:0] spacing = multi_vector_select ?
		{vector_spacing, 3'h0} : '0;
	wire logic [ivpc_pkg::OFFSET_W-1:0] vec_offset =
		{10'h000, 4'h0, pick.id} * {8'h00, spacing};
	wire logic [31:0] next_vec_addr = VECTOR_BASE +
		{14'h0000, vec_offset};

	wire logic [ivpc_pkg::SS_W-1:0] level_shadow_choice =
		shadow[pick.pri * ivpc_pkg::SS_W +: ivpc_pkg::SS_W];
	wire logic next_shadow_set = multi_vector_select ?
		(level_shadow_choice == ivpc_pkg::SS_SET1) :
		single_vector_shadow;

	ivpc_pkg::ivpc_present_s next_present;
	assign next_present = '{valid: pick.valid,
		number: {4'h0, pick.id},
		level: pick.pri,
		shadow_set: next_shadow_set,
		vector_addr: next_vec_addr};

	wire logic serviced = i_irq_ack && o_present.valid;
	// level 0 never reaches here, so trigger zero starts nothing
	wire logic next_prox_start = serviced &&
		(proximity_trigger_level != '0) &&
		(o_present.level <= proximity_trigger_level);

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path

	logic [31:0] rd_value;
	logic rd_mapped;

	wire logic [15:0] r_base = i_s_axi_araddr & ivpc_pkg::OFS_BASE_MASK;
	wire logic ar_take = i_s_axi_arvalid && o_s_axi_arready;
	wire logic next_rvalid = ar_take || (o_s_axi_rvalid && !i_s_axi_rready);
	wire logic [31:0] status_word =
		({21'h000000, single_req_level, last_serviced_number}) &
		ivpc_pkg::STATUS_MASK;

	always_comb begin
		rd_mapped = 1'b1;
		case (r_base)
			ivpc_pkg::OFS_CONTROL: rd_value = control;
			ivpc_pkg::OFS_SHADOW: rd_value = shadow;
			ivpc_pkg::OFS_STATUS: rd_value = status_word;
			ivpc_pkg::OFS_PROX_RELOAD: rd_value = prox_reload;
			ivpc_pkg::OFS_FLAGS: rd_value = {16'h0000, flags};
			ivpc_pkg::OFS_ENABLES: rd_value = {16'h0000, enables};
			ivpc_pkg::OFS_PRIO_G8: rd_value = prio[0];
			ivpc_pkg::OFS_PRIO_G9: rd_value = prio[1];
			ivpc_pkg::OFS_PRIO_G10: rd_value = prio[2];
			ivpc_pkg::OFS_PRIO_G11: rd_value = prio[3];
			default: begin
				rd_value = 32'h00000000;
				rd_mapped = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// state

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			o_s_axi_awready <= 1'b0;
			o_s_axi_wready <= 1'b0;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= ivpc_pkg::RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			o_s_axi_awready <= !next_aw_held && !next_bvalid;
			o_s_axi_wready <= !next_w_held && !next_bvalid;
			o_s_axi_bvalid <= next_bvalid;
			if (do_write) begin
				o_s_axi_bresp <= w_mapped ? ivpc_pkg::RESP_OKAY :
					ivpc_pkg::RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (aw_take) begin
			aw_addr <= i_s_axi_awaddr;
		end
		if (w_take) begin
			w_data <= i_s_axi_wdata;
			w_strb <= i_s_axi_wstrb;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= ivpc_pkg::RESET_VALUE;
			o_s_axi_rresp <= ivpc_pkg::RESP_OKAY;
		end else begin
			o_s_axi_arready <= !next_rvalid;
			o_s_axi_rvalid <= next_rvalid;
			if (ar_take) begin
				o_s_axi_rdata <= rd_value;
				o_s_axi_rresp <= rd_mapped ? ivpc_pkg::RESP_OKAY :
					ivpc_pkg::RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			control <= ivpc_pkg::RESET_VALUE;
			shadow <= ivpc_pkg::RESET_VALUE;
			prox_reload <= ivpc_pkg::RESET_VALUE;
			prio <= '0;
			flags <= '0;
			enables <= '0;
		end else begin
			control <= next_control;
			shadow <= next_shadow;
			prox_reload <= next_reload;
			prio <= next_prio;
			flags <= next_flags;
			enables <= enables_sw[ivpc_pkg::SRC_N-1:0];
		end
	end

	// pins pass two flops before the edge detector looks at them
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ext_meta <= '0;
			ext_sync <= '0;
			ext_prev <= '0;
		end else begin
			ext_meta <= i_ext_irq;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_present <= '0;
			o_prox_start <= 1'b0;
			o_prox_reload <= ivpc_pkg::RESET_VALUE;
			last_serviced_number <= '0;
			single_req_level <= '0;
		end else begin
			o_present <= next_present;
			o_prox_start <= next_prox_start;
			o_prox_reload <= next_reload;
			if (pick.valid) begin
				single_req_level <= pick.pri;
			end
			if (serviced) begin
				last_serviced_number <= o_present.number;
			end
		end
	end

endmodule : ivpc_ctrl
`default_nettype wire

// *** dv/ivpc_ctrl_sva.sv ***
// ivpc_ctrl_sva: port-level checks of the interrupt configuration block.
// assumes one i_clk domain and the synchronous, active-high i_reset.
`timescale 1ns/1ps
`default_nettype none
module ivpc_ctrl_sva (
	input wire logic i_clk, // system clock
	input wire logic i_reset, // sync reset
	input wire logic i_s_axi_wvalid, // write data valid
	input wire logic o_s_axi_awready, // write address ready
	input wire logic o_s_axi_wready, // write data ready
	input wire logic [1:0] o_s_axi_bresp, // write response
	input wire logic o_s_axi_bvalid, // write response valid
	input wire logic i_s_axi_bready, // write response ready
	input wire logic i_s_axi_arvalid, // read address valid
	input wire logic o_s_axi_arready, // read address ready
	input wire logic [31:0] o_s_axi_rdata, // read data
	input wire logic [1:0] o_s_axi_rresp, // read response
	input wire logic o_s_axi_rvalid, // read data valid
	input wire logic i_s_axi_rready, // read data ready
	input wire logic i_irq_ack, // core ack
	input wire ivpc_pkg::ivpc_present_s o_present, // presented vector
	input wire logic o_prox_start // proximity start pulse
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);
////////////////////////////////////////////////////////////////////////////
	bvalid_hold_a: assert property (
		o_s_axi_bvalid && !i_s_axi_bready |=>
		o_s_axi_bvalid && $stable(o_s_axi_bresp))
		else $error("write response dropped early");
	bresp_order_a: assert property (
		$rose(o_s_axi_bvalid) |->
		!$past(o_s_axi_awready) && !$past(o_s_axi_wready))
		else $error("write response before both channels taken");
	rvalid_hold_a: assert property (
		o_s_axi_rvalid && !i_s_axi_rready |=>
		o_s_axi_rvalid && $stable(o_s_axi_rdata))
		else $error("read data dropped early");
	read_answer_a: assert property (
		i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
		else $error("read answer late");
	arready_block_a: assert property (
		o_s_axi_rvalid |-> !o_s_axi_arready)
		else $error("second read accepted");
	unmapped_zero_a: assert property (
		o_s_axi_rvalid && o_s_axi_rresp == ivpc_pkg::RESP_SLVERR |->
		o_s_axi_rdata == 32'h00000000)
		else $error("refused read returned data");
	reset_clear_a: assert property (disable iff (1'b0)
		i_reset |=> !o_s_axi_bvalid && !o_s_axi_rvalid &&
		!o_present.valid && !o_prox_start)
		else $error("outputs not cleared by reset");
	prox_cause_a: assert property (
		o_prox_start |-> $past(i_irq_ack) && $past(o_present.valid))
		else $error("proximity start without an ack");
	level_nonzero_a: assert property (
		o_present.valid |-> o_present.level != 3'h0)
		else $error("level zero source presented");
endmodule : ivpc_ctrl_sva

bind ivpc_ctrl ivpc_ctrl_sva sva_u (
	.i_clk, .i_reset, .i_s_axi_wvalid, .o_s_axi_awready, .o_s_axi_wready,
	.o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_arvalid,
	.o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid,
	.i_s_axi_rready, .i_irq_ack, .o_present, .o_prox_start
);
`default_nettype wire

// *** dv/ivpc_core_model.sv ***
// ivpc_core_model: processor core that takes one presented vector per arm.
// assumes the block holds the vector as a level until acknowledged.
`timescale 1ns/1ps
`default_nettype none
module ivpc_core_model (
	input wire logic i_clk, // system clock
	input wire logic i_reset, // sync reset
	input wire ivpc_pkg::ivpc_present_s i_present, // offered vector
	input wire logic i_arm, // take the next vector
	input wire logic [3:0] i_delay, // wait cycles before ack
	output logic o_ack, // ack pulse to the block
	output ivpc_pkg::ivpc_present_s o_seen, // vector taken
	output logic o_busy // waiting for a vector
);
	logic [3:0] wait_cnt;

	// slow answers exercise a vector that must stay put while unanswered
	always_ff @(posedge i_clk) begin
		o_ack <= 1'b0;
		if (i_reset) begin
			o_busy <= 1'b0;
			wait_cnt <= 4'h0;
			o_seen <= '0;
		end else if (i_arm && !o_busy) begin
			o_busy <= 1'b1;
			wait_cnt <= i_delay;
		end else if (o_busy && i_present.valid) begin
			if (wait_cnt != 4'h0) begin
				wait_cnt <= wait_cnt - 4'h1;
			end else begin
				o_ack <= 1'b1;
				o_seen <= i_present;
				o_busy <= 1'b0;
			end
		end
	end
endmodule : ivpc_core_model
`default_nettype wire

// *** dv/interrupt_vector_priority_ctrl_test.sv ***
// interrupt_vector_priority_ctrl_test: register and vector sequences.
// assumes ivpc_ctrl with the default package size and a core model.
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_priority_ctrl_test;
	localparam logic [31:0] BASE = 32'h00001000;
	localparam logic [1:0] OK = ivpc_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = ivpc_pkg::RESP_SLVERR;
	localparam logic [15:0] CTL = 16'hF000;
	localparam logic [15:0] SHD = 16'hF010;
	localparam logic [15:0] STS = 16'hF020;
	localparam logic [15:0] RLD = 16'hF030;
	localparam logic [15:0] FLG = 16'hF040;
	localparam logic [15:0] G8 = 16'hF1C0;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [15:0] awaddr = 16'h0000;
	logic [15:0] araddr = 16'h0000;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, arm = 1'b0;
	logic [15:0] irq_req = 16'h0000;
	logic [4:0] ext_irq = 5'h00;
	logic [3:0] dly = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, ack, busy, prox_start;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, prox_reload;
	logic [6:0] vs;
	ivpc_pkg::ivpc_present_s present, seen;
	int failures = 0;
	int tests_run = 0;
	int prox_cnt = 0;
	int pc;
	logic [31:0] grp_ones [4] = '{32'h001F1F1F, 32'h1F1F1F00, 32'h001F1F1F,
		32'h1F1F0000};

	ivpc_ctrl #(.SMALL_PKG(1'b0), .VECTOR_BASE(BASE)) dut_u (
		.i_clk, .i_reset, .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
		.o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
		.i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
		.o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
		.i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
		.o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
		.i_s_axi_rready(rready), .i_irq_req(irq_req), .i_ext_irq(ext_irq),
		.i_irq_ack(ack), .o_present(present), .o_prox_start(prox_start),
		.o_prox_reload(prox_reload)
	);
	ivpc_core_model core_u (
		.i_clk, .i_reset, .i_present(present), .i_arm(arm), .i_delay(dly),
		.o_ack(ack), .o_seen(seen), .o_busy(busy)
	);

	always #4 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		if (prox_start) prox_cnt++;
	end
////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t ns: saw %h, wanted %h", $time, got, exp);
		end
	endtask : check

	task automatic axi_wr(input logic [15:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		logic got;
		@(posedge i_clk);
		got = 1'b0;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while ((awvalid || wvalid || !got) && n < 64) begin
			@(posedge i_clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bready && bvalid) begin
				got = 1'b1;
				bready <= 1'b0;
				check({30'h0, bresp}, {30'h0, er});
			end
		end
		if (!got) failures++;
	endtask : axi_wr

	task automatic axi_rd(input logic [15:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		int n;
		logic got;
		@(posedge i_clk);
		got = 1'b0;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!got && n < 64) begin
			@(posedge i_clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rready && rvalid) begin
				got = 1'b1;
				rready <= 1'b0;
				check(rdata, ed);
				check({30'h0, rresp}, {30'h0, er});
			end
		end
		if (!got) failures++;
	endtask : axi_rd

	task automatic take(input logic [7:0] num, input logic [2:0] lvl,
		input logic sh, input logic [31:0] addr);
		int n;
		@(posedge i_clk);
		arm <= 1'b1;
		@(posedge i_clk);
		arm <= 1'b0;
		@(posedge i_clk);
		n = 0;
		while (busy && n < 64) begin
			@(posedge i_clk);
			n++;
		end
		// a core that never answers must not pass on a stale vector
		check({31'h0, busy}, 32'h0);
		check({24'h0, seen.number}, {24'h0, num});
		check({29'h0, seen.level}, {29'h0, lvl});
		check({31'h0, seen.shadow_set}, {31'h0, sh});
		check(seen.vector_addr, addr);
	endtask : take

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up
////////////////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		failures++;
		wrap_up();
	end

	initial begin
		repeat (20) @(posedge i_clk);
		i_reset <= 1'b0;
		foreach (grp_ones[g]) axi_rd(G8 + 16'(g * 16), 32'h0, OK);
		axi_rd(CTL, 32'h0, OK);
		axi_rd(SHD, 32'h0, OK);
		// only legal spacing and shadow codes, holes still written as ones
		axi_wr(CTL, 32'hFF81FFFF, OK);
		axi_rd(CTL, 32'h0001171F, OK);
		axi_wr(SHD, 32'h1111111F, OK);
		axi_rd(SHD, 32'h11111111, OK);
		axi_wr(STS, 32'hFFFFFFFF, OK);
		axi_rd(STS, 32'h0, OK);
		axi_wr(RLD, 32'hA5C30F96, OK);
		axi_rd(RLD, 32'hA5C30F96, OK);
		check(prox_reload, 32'hA5C30F96);
		foreach (grp_ones[g]) begin
			axi_wr(G8 + 16'(g * 16), 32'hFFFFFFFF, OK);
			axi_rd(G8 + 16'(g * 16), grp_ones[g], OK);
		end
		axi_wr(CTL, 32'h0, OK);
		axi_wr(CTL + 16'h8, 32'h0000001F, OK);
		axi_rd(CTL, 32'h0000001F, OK);
		axi_wr(CTL + 16'h4, 32'h00000005, OK);
		axi_rd(CTL, 32'h0000001A, OK);
		axi_wr(CTL + 16'hC, 32'h0000100F, OK);
		axi_rd(CTL + 16'h4, 32'h00001015, OK);
		axi_wr(16'hE000, 32'h1, ERR);
		axi_rd(16'hE000, 32'h0, ERR);
		// level 0 on source 0 keeps it out; 2 beats 1 on subpriority
		axi_wr(SHD, 32'h0, OK);
		axi_wr(G8, 32'h00171600, OK);
		axi_wr(16'hF0C0, 32'h7, OK);
		axi_wr(CTL, 32'h00011500, OK);
		@(posedge i_clk);
		irq_req <= 16'h0007;
		@(posedge i_clk);
		irq_req <= 16'h0000;
		axi_rd(FLG, 32'h7, OK);
		take(8'h2, 3'h5, 1'b0, BASE + 32'h10);
		axi_rd(STS, 32'h00000502, OK);
		for (int k = 0; k < 8; k++) begin
			vs = (k == 0) ? 7'h0 : 7'h1 << (k - 1);
			axi_wr(CTL, {9'h0, vs, 16'h1000}, OK);
			axi_rd(CTL, {9'h0, vs, 16'h1000}, OK);
			check(present.vector_addr, BASE + {vs, 4'h0});
		end
		for (int t = 0; t < 8; t++) begin
			axi_wr(CTL, {19'h0, 1'b1, 1'b0, t[2:0], 8'h0}, OK);
			dly <= t[3:0];
			pc = prox_cnt;
			take(8'h2, 3'h5, 1'b0, BASE);
			repeat (4) @(posedge i_clk);
			check(32'(prox_cnt - pc), (t >= 5) ? 32'h1 : 32'h0);
		end
		axi_wr(SHD, 32'h00100000, OK);
		take(8'h2, 3'h5, 1'b1, BASE);
		axi_wr(CTL, 32'h00010000, OK);
		take(8'h2, 3'h5, 1'b0, BASE);
		axi_wr(SHD, 32'h00100001, OK);
		take(8'h2, 3'h5, 1'b1, BASE);
		axi_wr(G8, 32'h00171618, OK);
		take(8'h0, 3'h6, 1'b1, BASE);
		axi_wr(CTL, 32'h00001000, OK);
		axi_wr(SHD, 32'h01000000, OK);
		take(8'h0, 3'h6, 1'b1, BASE);
		// pins pass two flops and an edge detector before the flag
		axi_wr(FLG, 32'h0, OK);
		axi_wr(CTL, 32'h00000002, OK);
		@(posedge i_clk);
		ext_irq <= 5'h03;
		repeat (6) @(posedge i_clk);
		axi_rd(FLG, 32'h2, OK);
		ext_irq <= 5'h02;
		repeat (6) @(posedge i_clk);
		axi_rd(FLG, 32'h3, OK);
		axi_wr(FLG + 16'h4, 32'h1, OK);
		axi_rd(FLG, 32'h2, OK);
		wrap_up();
	end
endmodule : interrupt_vector_priority_ctrl_test
`default_nettype wire
